// ---- hw/irs_cfg.svh ----
`ifndef IRS_CFG_SVH
`define IRS_CFG_SVH

// Internal data memory geometry.
`define IRS_RAM_DEPTH 256
`define IRS_ADDR_W 8
`define IRS_DATA_W 8
`define IRS_HIGH_BIT 7
// Working register banks.
`define IRS_BANK_LO_POS 3
`define IRS_BANK_HI_POS 4
// Bit addressable area.
`define IRS_BIT_BASE 8'h20
`define IRS_BIT_ADDR_W 7
// Stack pointer.
`define IRS_SP_RESET 8'h07
`define IRS_SP_ONE 8'h01
`define IRS_SP_TWO 8'h02
// Program store and its fetch rate limit.
`define IRS_PROG_BYTES 4096
`define IRS_PROG_ADDR_W 12
`define IRS_CLK_KHZ 125000
`define IRS_FETCH_MAX_KHZ 8000
`define IRS_FETCH_DIV \
	((`IRS_CLK_KHZ + `IRS_FETCH_MAX_KHZ - 1) / `IRS_FETCH_MAX_KHZ)
`define IRS_DIV_W 5
// Shared port pins.
`define IRS_PINS 6

`endif

// ---- hw/irs_pkg.sv ----
package irs_pkg;

	typedef enum logic [4:0] {
		IRS_STK_NONE = 5'h01,
		IRS_STK_PUSH1 = 5'h02,
		IRS_STK_PUSH2 = 5'h04,
		IRS_STK_POP1 = 5'h08,
		IRS_STK_POP2 = 5'h10
	} irs_stack_op_type;

endpackage

// ---- hw/irs_ram_stack.sv ----
// Contract
// (RULE1) The block holds 256 bytes of internal data memory reached directly and indirectly.
// (RULE2) Addresses 0x00 to 0x7F reach the same bytes for direct and indirect access.
// (RULE3) At 0x80 to 0xFF indirect access reaches RAM and direct access goes to the special function space.
// (RULE4) Bytes 0x00 to 0x1F form four banks of eight working registers chosen by two status word bits.
// (RULE5) Bytes 0x20 to 0x2F are also reachable as 128 single bits, bit addresses 0x00 to 0x7F.
// (RULE6) A bit address selects byte 0x20 plus address/8 and bit position address mod 8.
// (RULE7) A single bit write changes only the chosen bit and keeps the other seven.
// (RULE8) After reset the stack pointer holds 0x07.
// (RULE9) The stack pointer spans the whole 256-byte space and software places the stack.
// (RULE10) A single byte push advances the stack pointer by one.
// (RULE11) Calls and interrupt entry save two bytes and advance the stack pointer by two.
// (RULE12) A single pop lowers the stack pointer by one and a return lowers it by two.
// (RULE13) The program store is 4 KB and fetches from it run at no more than 8 MHz.
// (RULE14) A pin taken by a shared peripheral gets its direction from that peripheral.
// (RULE15) Push increments then writes, pop reads then decrements.
// (RULE16) The stack pointer wraps modulo 256 with no flag.
`timescale 1ns/100ps
`include "irs_cfg.svh"

module irs_ram_stack #(
	parameter int RAM_DEPTH = `IRS_RAM_DEPTH,
	parameter int PROG_BYTES = `IRS_PROG_BYTES,
	parameter int FETCH_DIV = `IRS_FETCH_DIV
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic acc_valid_in,
	input wire logic acc_write_in,
	input wire logic acc_indirect_in,
	input wire logic [7:0] acc_addr_in,
	input wire logic [7:0] acc_wdata_in,
	output logic [7:0] acc_rdata_out,
	output logic sfr_sel_out,
	output logic sfr_write_out,
	output logic [7:0] sfr_addr_out,
	output logic [7:0] sfr_wdata_out,
	input wire logic [7:0] program_status_word_in,
	input wire logic wreg_valid_in,
	input wire logic wreg_write_in,
	input wire logic [2:0] wreg_index_in,
	input wire logic [7:0] wreg_wdata_in,
	output logic [7:0] wreg_rdata_out,
	input wire logic bit_valid_in,
	input wire logic bit_write_in,
	input wire logic [6:0] bit_addr_in,
	input wire logic bit_wdata_in,
	output logic bit_rdata_out,
	input wire irs_pkg::irs_stack_op_type stack_op_in,
	input wire logic [15:0] stack_wdata_in,
	output logic [15:0] stack_rdata_out,
	input wire logic sp_load_in,
	input wire logic [7:0] sp_wdata_in,
	output logic [7:0] stack_pointer_out,
	input wire logic fetch_req_in,
	input wire logic [11:0] fetch_addr_in,
	output logic fetch_grant_out,
	output logic [11:0] fetch_addr_out,
	input wire logic [5:0] port_direction_register_in,
	input wire logic [5:0] periph_sel_in,
	input wire logic [5:0] periph_oe_in,
	output logic [5:0] pin_oe_out
);

	// ==========================================================
	// Address helpers
	// ==========================================================
	function automatic logic [7:0] bit_byte(input logic [6:0] ba);
		bit_byte = `IRS_BIT_BASE + {4'h0, ba[6:3]}; // RULE6
	endfunction

	function automatic logic [7:0] bit_mask(input logic [6:0] ba);
		bit_mask = 8'h01 << ba[2:0]; // RULE6
	endfunction

	logic [7:0] mem_q [RAM_DEPTH];
	logic [7:0] sp_q;
	logic [7:0] sp_d;
	logic [7:0] sp_p1;
	logic [7:0] sp_p2;
	logic [7:0] sp_m1;
	logic [7:0] wreg_addr;
	logic [7:0] bit_byte_a;
	logic [7:0] bit_mask_a;
	logic acc_to_sfr;
	logic acc_ram_wr;
	logic [`IRS_DIV_W-1:0] div_q;

	assign sp_p1 = sp_q + `IRS_SP_ONE; // RULE16
	assign sp_p2 = sp_q + `IRS_SP_TWO; // RULE16
	assign sp_m1 = sp_q - `IRS_SP_ONE; // RULE16
	assign wreg_addr = {3'h0, program_status_word_in[`IRS_BANK_HI_POS],
		program_status_word_in[`IRS_BANK_LO_POS], wreg_index_in}; // RULE4
	assign bit_byte_a = bit_byte(bit_addr_in); // RULE5
	assign bit_mask_a = bit_mask(bit_addr_in);
	assign acc_to_sfr = !acc_indirect_in && acc_addr_in[`IRS_HIGH_BIT]; // RULE3
	assign acc_ram_wr = acc_valid_in && acc_write_in && !acc_to_sfr; // RULE2

	// ==========================================================
	// Stack pointer
	// ==========================================================
	always_comb
	begin
		sp_d = sp_q;
		if (sp_load_in)
			sp_d = sp_wdata_in; // RULE9
		else
			case (stack_op_in)
				irs_pkg::IRS_STK_PUSH1: sp_d = sp_p1; // RULE10
				irs_pkg::IRS_STK_PUSH2: sp_d = sp_p2; // RULE11
				irs_pkg::IRS_STK_POP1: sp_d = sp_m1; // RULE12
				irs_pkg::IRS_STK_POP2: sp_d = sp_q - `IRS_SP_TWO; // RULE12
				default: sp_d = sp_q;
			endcase
	end

	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
			sp_q <= `IRS_SP_RESET; // RULE8
		else
			sp_q <= sp_d;
	end

	assign stack_pointer_out = sp_q;

	// ==========================================================
	// Memory writes, stack first, then bits, registers, plain access
	// ==========================================================
	always_ff @(posedge ref_clk_in)
	begin
		if (stack_op_in == irs_pkg::IRS_STK_PUSH1)
			mem_q[sp_p1] <= stack_wdata_in[7:0]; // RULE15
		else if (stack_op_in == irs_pkg::IRS_STK_PUSH2)
		begin
			mem_q[sp_p1] <= stack_wdata_in[7:0]; // RULE11
			mem_q[sp_p2] <= stack_wdata_in[15:8]; // RULE11
		end
		else if (bit_valid_in && bit_write_in)
			mem_q[bit_byte_a] <= bit_wdata_in ?
				(mem_q[bit_byte_a] | bit_mask_a) :
				(mem_q[bit_byte_a] & ~bit_mask_a); // RULE7
		else if (wreg_valid_in && wreg_write_in)
			mem_q[wreg_addr] <= wreg_wdata_in; // RULE4
		else if (acc_ram_wr)
			mem_q[acc_addr_in] <= acc_wdata_in; // RULE1
	end

	// ==========================================================
	// Read data, one cycle after the request
	// ==========================================================
	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			acc_rdata_out <= 8'h00;
			wreg_rdata_out <= 8'h00;
			bit_rdata_out <= 1'b0;
			stack_rdata_out <= 16'h0000;
		end
		else
		begin
			if (acc_valid_in && !acc_write_in && !acc_to_sfr)
				acc_rdata_out <= mem_q[acc_addr_in]; // RULE2
			if (wreg_valid_in && !wreg_write_in)
				wreg_rdata_out <= mem_q[wreg_addr]; // RULE4
			if (bit_valid_in && !bit_write_in)
				bit_rdata_out <= |(mem_q[bit_byte_a] & bit_mask_a); // RULE5
			if (stack_op_in == irs_pkg::IRS_STK_POP1)
				stack_rdata_out <= {8'h00, mem_q[sp_q]}; // RULE15
			else if (stack_op_in == irs_pkg::IRS_STK_POP2)
				stack_rdata_out <= {mem_q[sp_q], mem_q[sp_m1]}; // RULE12
		end
	end

	// ==========================================================
	// Direct access to the upper half goes to the special function space
	// ==========================================================
	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sfr_sel_out <= 1'b0;
			sfr_write_out <= 1'b0;
			sfr_addr_out <= 8'h00;
			sfr_wdata_out <= 8'h00;
		end
		else
		begin
			sfr_sel_out <= acc_valid_in && acc_to_sfr; // RULE3
			sfr_write_out <= acc_valid_in && acc_to_sfr && acc_write_in;
			if (acc_valid_in && acc_to_sfr)
			begin
				sfr_addr_out <= acc_addr_in;
				sfr_wdata_out <= acc_wdata_in;
			end
		end
	end

	// ==========================================================
	// Program store fetch pacing
	// ==========================================================
	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
			div_q <= '0;
		else if (div_q == `IRS_DIV_W'(FETCH_DIV - 1))
			div_q <= '0;
		else
			div_q <= div_q + `IRS_DIV_W'(1);
	end

	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			fetch_grant_out <= 1'b0;
			fetch_addr_out <= 12'h000;
		end
		else
		begin
			fetch_grant_out <= fetch_req_in && div_q == '0; // RULE13
			if (fetch_req_in && div_q == '0)
				fetch_addr_out <= fetch_addr_in; // RULE13
		end
	end

	// ==========================================================
	// Pin direction with peripheral override
	// ==========================================================
	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
			pin_oe_out <= 6'h00;
		else
			pin_oe_out <= (periph_sel_in & periph_oe_in) |
				(~periph_sel_in & port_direction_register_in); // RULE14
	end

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);

	logic plain_cycle;
	assign plain_cycle = !sp_load_in;

	sequence s_push1;
		plain_cycle && stack_op_in == irs_pkg::IRS_STK_PUSH1;
	endsequence

	sequence s_push2;
		plain_cycle && stack_op_in == irs_pkg::IRS_STK_PUSH2;
	endsequence

	a_sp_after_reset: assert property ( // RULE8
		$past(reset_in) |-> sp_q == `IRS_SP_RESET)
		else $error("stack pointer not at reset value");

	a_push_one_step: assert property ( // RULE10
		s_push1 |=> sp_q == 8'($past(sp_q) + 8'h01) &&
			mem_q[sp_q] == $past(stack_wdata_in[7:0]))
		else $error("single push wrong");

	a_push_two_step: assert property ( // RULE11
		s_push2 |=> sp_q == 8'($past(sp_q) + 8'h02) &&
			mem_q[sp_q] == $past(stack_wdata_in[15:8]))
		else $error("double push wrong");

	a_pop_one_step: assert property ( // RULE12
		plain_cycle && stack_op_in == irs_pkg::IRS_STK_POP1 |=>
			sp_q == 8'($past(sp_q) - 8'h01))
		else $error("single pop wrong");

	a_push_pop_data: assert property ( // RULE15
		s_push1 ##1 (plain_cycle && stack_op_in == irs_pkg::IRS_STK_POP1)
			|=> stack_rdata_out[7:0] == $past(stack_wdata_in[7:0], 2))
		else $error("pop did not return pushed byte");

	a_bit_only_one: assert property ( // RULE7
		stack_op_in == irs_pkg::IRS_STK_NONE && bit_valid_in &&
			bit_write_in |=>
			(mem_q[$past(bit_byte_a)] & ~$past(bit_mask_a)) ==
			($past(mem_q[bit_byte_a]) & ~$past(bit_mask_a)) &&
			((mem_q[$past(bit_byte_a)] & $past(bit_mask_a)) != 8'h00) ==
			$past(bit_wdata_in))
		else $error("bit write touched other bits");

	a_direct_to_sfr: assert property ( // RULE3
		acc_valid_in && !acc_indirect_in && acc_addr_in[`IRS_HIGH_BIT] |=>
			sfr_sel_out && sfr_addr_out == $past(acc_addr_in))
		else $error("direct upper access not sent to sfr space");

	a_fetch_spacing: assert property ( // RULE13
		fetch_grant_out |=> !fetch_grant_out [*8])
		else $error("fetch faster than allowed");

	a_pin_override: assert property ( // RULE14
		periph_sel_in[0] |=> pin_oe_out[0] == $past(periph_oe_in[0]))
		else $error("peripheral did not own pin direction");

endmodule

// ---- verif/irs_core_model.sv ----
`timescale 1ns/100ps
// ====================
// Instruction side that issues stack operations and fetches.
module irs_core_model (
	input wire logic ref_clk_in,
	input wire logic fetch_en_in,
	input wire logic fetch_grant_in,
	output irs_pkg::irs_stack_op_type stack_op_out,
	output logic [15:0] stack_wdata_out,
	output logic fetch_req_out,
	output logic [11:0] fetch_addr_out
);
	initial
	begin
		stack_op_out = irs_pkg::IRS_STK_NONE;
		stack_wdata_out = 16'h0000;
		fetch_addr_out = 12'h000;
	end
	// The request follows fetch_en_in and stays up across grants; each grant moves the address on.
	assign fetch_req_out = fetch_en_in;
	always @(negedge ref_clk_in)
	begin
		if (fetch_grant_in)
			fetch_addr_out <= fetch_addr_out + 12'h001;
	end
	// One operation, or two back to back, then one idle cycle so that
	// the next call never lowers and raises the operation in one step.
	task stack_do(input irs_pkg::irs_stack_op_type op,
		input logic [15:0] d,
		input irs_pkg::irs_stack_op_type op2 = irs_pkg::IRS_STK_NONE);
		stack_op_out = op;
		stack_wdata_out = d;
		@(negedge ref_clk_in);
		if (op2 != irs_pkg::IRS_STK_NONE)
		begin
			stack_op_out = op2;
			@(negedge ref_clk_in);
		end
		stack_op_out = irs_pkg::IRS_STK_NONE;
		stack_wdata_out = ~d;
		@(negedge ref_clk_in);
	endtask
endmodule

// ---- verif/irs_ram_stack_tb_top.sv ----
`timescale 1ns/100ps
module irs_ram_stack_tb_top;
	localparam int FETCH_GAP = (125000 + 7999) / 8000;
	logic ref_clk_in, reset_in, acc_valid_in, acc_write_in, acc_indirect_in;
	logic [7:0] acc_addr_in, acc_wdata_in, acc_rdata_out, sfr_addr_out;
	logic [7:0] sfr_wdata_out, program_status_word_in, wreg_wdata_in;
	logic [7:0] wreg_rdata_out, sp_wdata_in, stack_pointer_out, a, d;
	logic sfr_sel_out, sfr_write_out, wreg_valid_in, wreg_write_in;
	logic bit_valid_in, bit_write_in, bit_wdata_in, bit_rdata_out;
	logic sp_load_in, fetch_req_in, fetch_grant_out, fetch_en;
	logic [2:0] wreg_index_in;
	logic [6:0] bit_addr_in;
	irs_pkg::irs_stack_op_type stack_op_in;
	logic [15:0] stack_wdata_in, stack_rdata_out;
	logic [11:0] fetch_addr_in, fetch_addr_out;
	logic [5:0] port_direction_register_in, periph_sel_in, periph_oe_in;
	logic [5:0] pin_oe_out;
	logic [31:0] seed = 32'h00016673;
	int num_errors = 0;
	int tests_run = 0;
	int n;
	irs_ram_stack #(.FETCH_DIV(FETCH_GAP)) DUT (.ref_clk_in, .reset_in,
		.acc_valid_in, .acc_write_in, .acc_indirect_in, .acc_addr_in,
		.acc_wdata_in, .acc_rdata_out, .sfr_sel_out, .sfr_write_out,
		.sfr_addr_out, .sfr_wdata_out, .program_status_word_in,
		.wreg_valid_in, .wreg_write_in, .wreg_index_in, .wreg_wdata_in,
		.wreg_rdata_out, .bit_valid_in, .bit_write_in, .bit_addr_in,
		.bit_wdata_in, .bit_rdata_out, .stack_op_in, .stack_wdata_in,
		.stack_rdata_out, .sp_load_in, .sp_wdata_in, .stack_pointer_out,
		.fetch_req_in, .fetch_addr_in, .fetch_grant_out, .fetch_addr_out,
		.port_direction_register_in, .periph_sel_in, .periph_oe_in,
		.pin_oe_out);
	irs_core_model core (.ref_clk_in, .fetch_en_in(fetch_en),
		.fetch_grant_in(fetch_grant_out), .stack_op_out(stack_op_in),
		.stack_wdata_out(stack_wdata_in), .fetch_req_out(fetch_req_in),
		.fetch_addr_out(fetch_addr_in));
	initial
	begin
		ref_clk_in = 0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Valid stays up after a call, so back-to-back requests of one kind
	// never drop and raise it in one step; the other kind releases it.
	task acc(input logic w, ind, input logic [7:0] ad, dt);
		bit_valid_in = 0;
		acc_valid_in = 1;
		acc_write_in = w;
		acc_indirect_in = ind;
		acc_addr_in = ad;
		acc_wdata_in = dt;
		@(negedge ref_clk_in);
	endtask
	task bitop(input logic w, input logic [6:0] ad, input logic dt);
		acc_valid_in = 0;
		bit_valid_in = 1;
		bit_write_in = w;
		bit_addr_in = ad;
		bit_wdata_in = dt;
		@(negedge ref_clk_in);
	endtask
	task complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		{acc_valid_in, acc_write_in, acc_indirect_in, wreg_valid_in} = 0;
		{wreg_write_in, bit_valid_in, bit_write_in, bit_wdata_in} = 0;
		{acc_addr_in, acc_wdata_in, wreg_wdata_in, sp_wdata_in} = 0;
		{wreg_index_in, bit_addr_in, sp_load_in, fetch_en} = 0;
		program_status_word_in = 8'h00;
		{port_direction_register_in, periph_sel_in, periph_oe_in} = 0;
		reset_in = 1;
		repeat (8) @(negedge ref_clk_in);
		reset_in = 0;
		chk(stack_pointer_out, 16'h0007);
		for (int i = 0; i < 32; i++)
		begin
			a = 8'(rnd()) & 8'h7F;
			d = 8'(rnd());
			acc(1, 0, a, d);
			acc(0, 1, a, 8'h00);
			chk(acc_rdata_out, d);
			a = a | 8'h80;
			acc(1, 1, a, d);
			acc(1, 0, a, ~d);
			chk({sfr_sel_out, sfr_write_out, sfr_wdata_out}, {2'h3, ~d});
			chk(sfr_addr_out, a);
			acc(0, 1, a, 8'h00);
			chk(acc_rdata_out, d);
		end
		$display("test addressing done");
		for (int i = 0; i < 32; i++)
		begin
			d = 8'(rnd());
			program_status_word_in = 8'(i[4:3]) << 3;
			{wreg_valid_in, wreg_write_in, wreg_index_in} = {2'h3, i[2:0]};
			wreg_wdata_in = d;
			@(negedge ref_clk_in);
			wreg_write_in = 0;
			acc(0, 1, 8'(i), 8'h00);
			chk(acc_rdata_out, d);
			chk(wreg_rdata_out, d);
		end
		wreg_valid_in = 0;
		$display("test banks done");
		acc(1, 0, 8'h28, 8'h00);
		bitop(1, 7'h42, 1);
		acc(0, 0, 8'h28, 8'h00);
		chk(acc_rdata_out, 16'h0004);
		for (int i = 0; i < 32; i++)
		begin
			a = (i == 0) ? 8'h07 : 8'(rnd()) & 8'h7F;
			d = (i == 0) ? 8'h80 : 8'(rnd());
			acc(1, 0, 8'h20 + (a >> 3), d);
			bitop(0, a[6:0], 0);
			chk(bit_rdata_out, d[a[2:0]]);
			bitop(1, a[6:0], ~d[a[2:0]]);
			acc(0, 0, 8'h20 + (a >> 3), 8'h00);
			chk(acc_rdata_out, d ^ (8'h01 << a[2:0]));
		end
		$display("test bits done");
		sp_wdata_in = 8'hFE;
		sp_load_in = 1;
		@(negedge ref_clk_in);
		sp_load_in = 0;
		chk(stack_pointer_out, 16'h00FE);
		core.stack_do(irs_pkg::IRS_STK_PUSH1, 16'h00AB);
		chk(stack_pointer_out, 16'h00FF);
		acc(0, 1, 8'hFF, 8'h00);
		chk(acc_rdata_out, 16'h00AB);
		acc_valid_in = 0;
		core.stack_do(irs_pkg::IRS_STK_PUSH2, 16'h1234);
		chk(stack_pointer_out, 16'h0001);
		core.stack_do(irs_pkg::IRS_STK_POP2, 16'h0000);
		chk({stack_pointer_out, stack_rdata_out}, 24'hFF1234);
		core.stack_do(irs_pkg::IRS_STK_POP1, 16'h0000);
		chk({stack_pointer_out, stack_rdata_out}, 24'hFE00AB);
		core.stack_do(irs_pkg::IRS_STK_PUSH1, 16'h005A,
			irs_pkg::IRS_STK_POP1);
		chk({stack_pointer_out, stack_rdata_out}, 24'hFE005A);
		$display("test stack done");
		for (int i = 0; i < 16; i++)
		begin
			{port_direction_register_in, periph_sel_in, periph_oe_in} =
				18'(rnd());
			@(negedge ref_clk_in);
			chk(pin_oe_out, (periph_sel_in & periph_oe_in) |
				(~periph_sel_in & port_direction_register_in));
		end
		$display("test pins done");
		fetch_en = 1;
		for (n = 0; fetch_grant_out !== 1'b1 && n < 40; n++)
			@(negedge ref_clk_in);
		if (n == 40)
		begin
			num_errors++;
			$display("MISMATCH %0t no fetch grant", $time);
		end
		n = 0;
		do
		begin
			@(negedge ref_clk_in);
			n++;
		end
		while (fetch_grant_out !== 1'b1 && n < 40);
		chk(n, FETCH_GAP);
		chk(fetch_addr_out, 16'h0001);
		fetch_en = 0;
		$display("test fetch done");
		reset_in = 1;
		@(negedge ref_clk_in);
		chk(stack_pointer_out, 16'h0007);
		reset_in = 0;
		$display("test reset done");
		complete_run();
	end
endmodule
